//--- common/rss_pkg.sv
// Purpose: Constants and types for the reset, self-test and state recall controller
// Assumes: 40 MHz clock, relay image held in an external nonvolatile store
// Notes: Command decoding to opcodes is done upstream of this block
// What this block does
// - Reset restores relays from stored slot zero
// - Factory-blank slot zero opens every relay
// - Reset clears scan, include, exclude lists
// - Self-test query runs test, returns integer
// - Reply zero on pass, nonzero on fail
// - Codes: 1 ROM, 2 RAM, 3 NV, 4 timer
// - Any self-test failure pushes error entry
// - Error entry carries expected and actual detail
// - Reply withheld until test completes, thirty seconds
// - Recall slot argument lies in 0..100
// - Recall without argument uses slot 100
// - Recall reloads every relay state
// - Recall changes relay states only
package rss_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SELFTEST_SEC = 30;
  localparam longint SELFTEST_CYC = longint'(SELFTEST_SEC) * longint'(CLK_HZ);
  // ----------------------------------------
  // Slots and codes
  // ----------------------------------------
  localparam logic [6:0] SLOT_POWERON = 7'h00;
  localparam logic [6:0] SLOT_DEFAULT = 7'h64;
  localparam logic [6:0] SLOT_MAX = 7'h64;
  localparam logic [2:0] TST_PASS = 3'h0;
  localparam logic [2:0] TST_ROM = 3'h1;
  localparam logic [2:0] TST_RAM = 3'h2;
  localparam logic [2:0] TST_NVM = 3'h3;
  localparam logic [2:0] TST_TMR = 3'h4;
  localparam logic [2:0] ERR_SELFTEST = 3'h1;
  localparam logic [2:0] ERR_BADSLOT = 3'h2;
  // Reset values of trigger configuration
  localparam logic [1:0] TRIG_SRC_IMM = 2'h0;
  localparam logic [15:0] TRIG_COUNT_RST = 16'h0001;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [3:0] TRIG_OUT_NONE = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_COPY = 3'b010,
    ST_TEST = 3'b011,
    ST_REPLY = 3'b100
  } rss_state_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_RESET = 2'b01,
    CMD_SELFTEST = 2'b10,
    CMD_RECALL = 2'b11
  } rss_cmd_t;
  // Command from the parser
  typedef struct packed {
    rss_cmd_t op;
    logic hasSlot;
    logic [7:0] slot;
  } rss_req_t;
  // One error queue entry
  typedef struct packed {
    logic [2:0] kind;
    logic [2:0] code;
    logic [15:0] addr;
    logic [15:0] expected;
    logic [15:0] actual;
  } rss_err_t;
  // Result of the hardware self-test engine
  typedef struct packed {
    logic [2:0] code;
    logic [15:0] addr;
    logic [15:0] expected;
    logic [15:0] actual;
  } rss_tres_t;
  // Configuration defaults after reset
  typedef struct packed {
    logic [1:0] trigSrc;
    logic [15:0] trigCount;
    logic [31:0] trigInDelay;
    logic [3:0] trigOutputLineSelect;
    logic [31:0] trigOutDelay;
    logic monitorOn;
    logic scanDefined;
    logic includeDefined;
    logic excludeDefined;
  } rss_cfg_t;
endpackage : rss_pkg

//--- core/rss_wait_timer.sv
// Purpose: Down-counter that holds the self-test reply for its full duration
// Assumes: start is a one-cycle pulse
// Notes: done pulses one cycle when the count expires
`timescale 1ns/10ps
module rss_wait_timer
  import rss_pkg::*;
#(
  parameter longint CYCLES = SELFTEST_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  initial begin
    if (CYCLES < 2) begin
      $error("rss_wait_timer needs at least two cycles");
    end
  end
  logic [35:0] cnt_q;
  logic [35:0] cnt_d;
  logic expire;
  // Count loads on start and runs down to zero, expiring at one
  assign expire = busy && (cnt_q == 36'h0_0000_0001);
  assign cnt_d = start ? 36'(CYCLES) : (busy ? cnt_q - 36'h0_0000_0001 : cnt_q);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      done <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
      done <= expire && !start;
    end
  end
  assign busy = (cnt_q != '0);
endmodule : rss_wait_timer

//--- core/rss_controller.sv
// Purpose: Reset defaults, self-test query and relay state recall sequencing
// Assumes: Nonvolatile store answers a read one cycle after its strobe
// Notes: Relay image is moved word by word from the store to the driver latch
`timescale 1ns/10ps
module rss_controller
  import rss_pkg::*;
#(
  parameter int NUM_WORDS = 16,
  parameter longint TEST_CYCLES = SELFTEST_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clkEn,
  // Command port from the parser
  input wire logic reqValid,
  input wire rss_req_t req,
  output logic reqReady,
  // Reply to the host
  output logic replyValid,
  output logic [2:0] replyCode,
  // Error queue push
  output logic errPush,
  output rss_err_t errEntry,
  // Configuration defaults
  output rss_cfg_t cfg,
  // Nonvolatile store
  output logic nvRead,
  output logic [6:0] nvSlot,
  output logic [7:0] nvWord,
  input wire logic [15:0] nvData,
  input wire logic nvBlank,
  // Relay drivers
  output logic relayWrite,
  output logic [7:0] relayWord,
  output logic [15:0] relayData,
  // Self-test engine
  output logic testStart,
  input wire logic testDone,
  input wire rss_tres_t testResult,
  input wire logic powerUpFail
);
  initial begin
    if (NUM_WORDS < 1 || NUM_WORDS > 256) begin
      $error("rss_controller NUM_WORDS must be 1 to 256");
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic slotOk(input logic [7:0] s);
    slotOk = (s <= {1'b0, SLOT_MAX});
  endfunction : slotOk
  // Engine codes beyond the documented set are folded onto the memory fault code
  function automatic logic [2:0] clampCode(input logic [2:0] c);
    clampCode = (c > TST_TMR) ? TST_RAM : c;
  endfunction : clampCode
  function automatic rss_cfg_t cfgDefault();
    rss_cfg_t c;
    c.trigSrc = TRIG_SRC_IMM;
    c.trigCount = TRIG_COUNT_RST;
    c.trigInDelay = DELAY_RST;
    c.trigOutputLineSelect = TRIG_OUT_NONE;
    c.trigOutDelay = DELAY_RST;
    c.monitorOn = 1'b0;
    c.scanDefined = 1'b0;
    c.includeDefined = 1'b0;
    c.excludeDefined = 1'b0;
    cfgDefault = c;
  endfunction : cfgDefault
  localparam logic [7:0] LAST_WORD = 8'(NUM_WORDS - 1);
  // ----------------------------------------
  // State
  // ----------------------------------------
  rss_state_t state_q;
  rss_state_t state_d;
  logic [7:0] word_q;
  logic [6:0] slot_q;
  logic boot_q;
  logic timerBusy;
  logic testSeen_q;
  rss_tres_t res_q;
  // Decode of the incoming request
  wire logic take = reqValid && reqReady;
  wire logic isReset = take && (req.op == CMD_RESET);
  wire logic isTest = take && (req.op == CMD_SELFTEST);
  wire logic isRecall = take && (req.op == CMD_RECALL);
  wire logic badSlot = isRecall && req.hasSlot && !slotOk(req.slot);
  wire logic [6:0] reqSlot = req.hasSlot ? req.slot[6:0] : SLOT_DEFAULT;
  wire logic lastWord = (word_q == LAST_WORD);
  wire logic testFinished = testSeen_q && !timerBusy;
  assign reqReady = (state_q == ST_IDLE) && !boot_q;
  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (boot_q || isReset) begin
          state_d = ST_LOAD;
        end else if (isRecall && !badSlot) begin
          state_d = ST_LOAD;
        end else if (isTest) begin
          state_d = ST_TEST;
        end
      end
      ST_LOAD: state_d = ST_COPY;
      ST_COPY: begin
        if (lastWord) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_LOAD;
        end
      end
      ST_TEST: begin
        if (testFinished) begin
          state_d = ST_REPLY;
        end
      end
      ST_REPLY: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end
  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      boot_q <= 1'b1;
    end else if (clkEn) begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        boot_q <= 1'b0;
      end
    end
  end
  // Slot latch: reset and boot use slot zero, recall its own slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= SLOT_POWERON;
    end else if (clkEn && state_q == ST_IDLE) begin
      if (boot_q || isReset) begin
        slot_q <= SLOT_POWERON;
      end else if (isRecall) begin
        slot_q <= reqSlot;
      end
    end
  end
  // Word walk over the whole relay image
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= '0;
    end else if (clkEn) begin
      if (state_q == ST_IDLE) begin
        word_q <= '0;
      end else if (state_q == ST_COPY) begin
        word_q <= word_q + 8'h01;
      end
    end
  end
  assign nvRead = (state_q == ST_LOAD);
  assign nvSlot = slot_q;
  assign nvWord = word_q;
  // Relay write: blank slot zero opens every relay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      relayWrite <= 1'b0;
      relayWord <= '0;
      relayData <= '0;
    end else if (clkEn) begin
      relayWrite <= (state_q == ST_COPY);
      relayWord <= word_q;
      if (state_q == ST_COPY) begin
        relayData <= (nvBlank && slot_q == SLOT_POWERON) ? 16'h0000 : nvData;
      end
    end
  end
  // Configuration defaults; recall leaves these untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= cfgDefault();
    end else if (clkEn && isReset) begin
      cfg <= cfgDefault();
    end
  end
  // Self-test: engine result is latched, reply waits for the timer
  assign testStart = isTest;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      testSeen_q <= 1'b0;
      res_q <= '0;
    end else if (clkEn) begin
      if (isTest) begin
        testSeen_q <= 1'b0;
      end else if (testDone && state_q == ST_TEST) begin
        testSeen_q <= 1'b1;
        res_q <= testResult;
      end
    end
  end
  rss_wait_timer #(
    .CYCLES(TEST_CYCLES)
  ) uTimer (
    .clock(clock),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .start(isTest),
    .busy(timerBusy),
    .done()
  );
  // Code is clamped so only documented values leave the block
  wire logic [2:0] safeCode = clampCode(res_q.code);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      replyValid <= 1'b0;
      replyCode <= TST_PASS;
    end else if (clkEn) begin
      replyValid <= (state_q == ST_TEST) && testFinished;
      if ((state_q == ST_TEST) && testFinished) begin
        replyCode <= safeCode;
      end
    end
  end
  // Error queue push for failed tests and bad slots
  wire logic testFail = (state_q == ST_TEST) && testFinished && (safeCode != TST_PASS);
  wire logic bootFail = boot_q && powerUpFail;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errPush <= 1'b0;
      errEntry <= '0;
    end else if (clkEn) begin
      errPush <= testFail || bootFail || badSlot;
      if (testFail) begin
        errEntry <= {ERR_SELFTEST, safeCode, res_q.addr, res_q.expected, res_q.actual};
      end else if (bootFail) begin
        // Power-up result is taken straight from the engine; res_q is still cleared
        errEntry <= {ERR_SELFTEST, clampCode(testResult.code), testResult.addr,
          testResult.expected, testResult.actual};
      end else if (badSlot) begin
        errEntry <= {ERR_BADSLOT, 3'h0, 8'h00, req.slot, 16'h0000, 16'h0000};
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_REPLY_CODES: assert property (@(posedge clock) disable iff (!rst_n)
    replyValid |-> replyCode <= TST_TMR) else $error("Self-test code out of range");
  AST_FAIL_ERR: assert property (@(posedge clock) disable iff (!rst_n)
    replyValid && replyCode != TST_PASS |-> errPush && errEntry.kind == ERR_SELFTEST)
    else $error("Failed self-test left no error entry");
  AST_NO_EARLY_REPLY: assert property (@(posedge clock) disable iff (!rst_n)
    replyValid |-> $past(!timerBusy)) else $error("Reply before test time elapsed");
  AST_BADSLOT_NOMOVE: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && badSlot |=> errPush && state_q == ST_IDLE) else $error("Bad slot not rejected");
  AST_DEFAULT_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isRecall && !req.hasSlot |=> slot_q == SLOT_DEFAULT)
    else $error("Recall default slot wrong");
  AST_RESET_SLOT0: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isReset |=> slot_q == SLOT_POWERON && state_q == ST_LOAD)
    else $error("Reset did not restore slot zero");
  AST_BLANK_OPEN: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && state_q == ST_COPY && nvBlank && slot_q == SLOT_POWERON
    |=> relayWrite && relayData == 16'h0000) else $error("Blank slot zero did not open relays");
  AST_RESET_CFG: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isReset |=> !cfg.scanDefined && !cfg.includeDefined && !cfg.excludeDefined)
    else $error("Lists survive reset");
  AST_RECALL_CFG: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isRecall |=> $stable(cfg)) else $error("Recall changed configuration");
  AST_TRIG_CFG: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isReset |=> cfg.trigCount == TRIG_COUNT_RST && !cfg.monitorOn)
    else $error("Trigger defaults not restored");
  AST_ONE_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && nvRead |=> !nvRead) else $error("Store read strobe longer than one cycle");
  AST_COPY_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && state_q == ST_COPY |=> relayWrite) else $error("Copied word not written");
  AST_BOOT_WALK: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && boot_q |=> state_q == ST_LOAD && slot_q == SLOT_POWERON)
    else $error("Boot did not start slot zero walk");
  AST_BOOT_ERR: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && boot_q && powerUpFail |=> errPush && errEntry.kind == ERR_SELFTEST)
    else $error("Power-up failure left no error entry");
  AST_REPLY_HELD: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && state_q == ST_TEST && timerBusy |=> !replyValid)
    else $error("Reply while hold timer running");
  AST_PASS_NO_ERR: assert property (@(posedge clock) disable iff (!rst_n)
    replyValid && replyCode == TST_PASS |-> !errPush)
    else $error("Passing self-test pushed an error");
  AST_RECALL_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isRecall && req.hasSlot && !badSlot |=> slot_q == $past(req.slot[6:0]))
    else $error("Recall slot not latched");
  AST_BADSLOT_ENTRY: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && badSlot |=> errEntry.kind == ERR_BADSLOT && errEntry.addr[7:0] == $past(req.slot))
    else $error("Bad slot entry wrong");
  AST_TEST_START: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && isTest |=> state_q == ST_TEST && timerBusy)
    else $error("Self-test not started");
endmodule : rss_controller

//--- bench/rss_store_model.sv
// Purpose: Far-side model of the relay image store and the self-test engine
// Assumes: Store answers in the cycle after each read strobe
// Notes: Outside an answer the data bus toggles, so stale words never pass for good ones
`timescale 1ns/10ps
module rss_store_model
  import rss_pkg::*;
(
  // Clock
  input wire logic clock,
  // Store side
  input wire logic nvRead,
  input wire logic [6:0] nvSlot,
  input wire logic [7:0] nvWord,
  output logic [15:0] nvData,
  output logic nvBlank,
  input wire logic blankZero,
  // Test engine side
  input wire logic testStart,
  output logic testDone,
  output rss_tres_t testResult,
  input wire logic [7:0] engDelay,
  input wire rss_tres_t engResult
);
  logic [7:0] engCnt;
  initial begin
    nvData = 16'h0000;
    testDone = 1'b0;
    engCnt = 8'h00;
    testResult = '0;
  end
  // ----------------------------------------
  // Store
  // ----------------------------------------
  // Slot zero reads as factory contents while blankZero is set
  assign nvBlank = blankZero && (nvSlot == SLOT_POWERON);
  // Word pattern depends on slot and index so a wrong slot shows up
  always @(posedge clock) begin
    if (nvRead) begin
      nvData <= {nvSlot, 1'b0, nvWord} ^ 16'ha5c3;
    end else begin
      nvData <= ~nvData;
    end
  end
  // ----------------------------------------
  // Self-test engine
  // ----------------------------------------
  // Finishes engDelay cycles after start, early or late against the hold timer
  always @(posedge clock) begin
    testDone <= testStart ? 1'b0 : (engCnt == 8'h01);
    testResult <= (!testStart && engCnt == 8'h01) ? engResult : ~testResult;
    if (testStart) begin
      engCnt <= engDelay;
    end else if (engCnt != 8'h00) begin
      engCnt <= engCnt - 8'h01;
    end
  end
endmodule : rss_store_model

//--- bench/testbench.sv
// Purpose: Self-checking bench for the reset, self-test and recall controller
// Assumes: Short image and short self-test hold set by parameters
// Notes: Expected results are queued by the driver and popped by the monitor
`timescale 1ns/10ps
module testbench;
  import rss_pkg::*;
  localparam int NW = 4;
  localparam longint TC = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  rss_req_t req = '0;
  logic reqReady, replyValid, errPush, nvRead, nvBlank, relayWrite, testStart, testDone;
  logic [2:0] replyCode;
  rss_err_t errEntry;
  rss_cfg_t cfg;
  logic [6:0] nvSlot;
  logic [7:0] nvWord, relayWord;
  logic [15:0] nvData, relayData;
  rss_tres_t testResult;
  logic blankZero = 1'b1;
  logic powerUpFail = 1'b0;
  logic [7:0] engDelay = 8'h01;
  rss_tres_t engResult = '0;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h43b6_7836;
  longint cyc = 0;
  longint tStart = 0;
  logic [23:0] relayQ[$];
  logic [2:0] replyQ[$];
  logic [107:0] errQ[$];
  logic [127:0] e;
  logic [89:0] cfgExp;
  // ----------------------------------------
  // Clock and instances
  // ----------------------------------------
  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  rss_controller #(.NUM_WORDS(NW), .TEST_CYCLES(TC)) i_dut (.clock(clock), .rst_n(rst_n),
    .clkEn(1'b1), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .replyValid(replyValid), .replyCode(replyCode), .errPush(errPush), .errEntry(errEntry),
    .cfg(cfg), .nvRead(nvRead), .nvSlot(nvSlot), .nvWord(nvWord), .nvData(nvData),
    .nvBlank(nvBlank), .relayWrite(relayWrite), .relayWord(relayWord),
    .relayData(relayData), .testStart(testStart), .testDone(testDone),
    .testResult(testResult), .powerUpFail(powerUpFail));
  rss_store_model i_model (.clock(clock), .nvRead(nvRead), .nvSlot(nvSlot), .nvWord(nvWord),
    .nvData(nvData), .nvBlank(nvBlank), .blankZero(blankZero), .testStart(testStart),
    .testDone(testDone), .testResult(testResult), .engDelay(engDelay),
    .engResult(engResult));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    cmp_count++;
    if (exp !== got) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Bounded wait for the block to be free again, seen where outputs are settled
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clock);
    while (reqReady !== 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    chk("ready", 1, reqReady);
  endtask : wait_ready
  // Request held until the edge at which ready is high
  task automatic send(input rss_cmd_t op, input logic has, input logic [7:0] slot);
    @(posedge clock);
    reqValid <= 1'b1;
    req <= '{op: op, hasSlot: has, slot: slot};
    wait_ready();
    @(posedge clock);
    reqValid <= 1'b0;
  endtask : send
  // Word order is index zero first; a blank slot reads as all relays open
  task automatic walk(input logic [6:0] s, input logic blank);
    for (int w = 0; w < NW; w++) begin
      relayQ.push_back({8'(w), blank ? 16'h0000 : ({s, 1'b0, 8'(w)} ^ 16'ha5c3)});
    end
  endtask : walk
  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(negedge clock) begin
    if (testStart === 1'b1) begin
      tStart = cyc;
    end
    if (relayWrite === 1'b1) begin
      e = (relayQ.size() != 0) ? relayQ.pop_front() : 'x;
      chk("relay", e, {relayWord, relayData});
    end
    if (replyValid === 1'b1) begin
      e = (replyQ.size() != 0) ? replyQ.pop_front() : 'x;
      chk("reply", e, replyCode);
      chk("reply hold", 1, (cyc - tStart) >= TC);
    end
    if (errPush === 1'b1) begin
      e = (errQ.size() != 0) ? errQ.pop_front() : 'x;
      chk("error", e[53:0], errEntry & e[107:54]);
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    logic [7:0] s;
    logic [47:0] d;
    cfgExp = {TRIG_SRC_IMM, TRIG_COUNT_RST, DELAY_RST, TRIG_OUT_NONE, DELAY_RST, 4'h0};
    walk(SLOT_POWERON, 1'b1);
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk("cfg", cfgExp, cfg);
    // Slot zero stays factory-blank until the boot walk has read it
    wait_ready();
    @(posedge clock);
    blankZero <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'h64 : 8'(rnd() % 101);
      walk(s[6:0], 1'b0);
      send(CMD_RECALL, 1'b1, s);
    end
    walk(SLOT_DEFAULT, 1'b0);
    send(CMD_RECALL, 1'b0, 8'(rnd()));
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 8'h65 : 8'(101 + rnd() % 155);
      errQ.push_back({3'h7, 3'h0, 16'h00ff, 32'h0, ERR_BADSLOT, 3'h0, 8'h00, s, 32'h0});
      send(CMD_RECALL, 1'b1, s);
    end
    wait_ready();
    chk("cfg kept", cfgExp, cfg);
    for (int c = 0; c < 5; c++) begin
      d = {rnd(), 16'(rnd())};
      engResult <= {3'(c), d};
      engDelay <= (c % 2 == 1) ? 8'd30 : 8'd1;
      replyQ.push_back(3'(c));
      if (c != 0) begin
        errQ.push_back({54'h3f_ffff_ffff_ffff, ERR_SELFTEST, 3'(c), d});
      end
      send(CMD_SELFTEST, 1'b0, 8'h00);
      // Engine result must be taken before the next value is set up
      wait_ready();
    end
    walk(SLOT_POWERON, 1'b0);
    send(CMD_RESET, 1'b0, 8'h00);
    wait_ready();
    walk(SLOT_POWERON, 1'b1);
    errQ.push_back({3'h7, 51'h0, ERR_SELFTEST, 51'h0});
    @(posedge clock);
    blankZero <= 1'b1;
    powerUpFail <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    powerUpFail <= 1'b0;
    wait_ready();
    chk("cfg reset", cfgExp, cfg);
    repeat (5) @(negedge clock);
    chk("left over", 0, relayQ.size() + replyQ.size() + errQ.size());
    end_sim();
  end
  // Watchdog well past the longest expected run
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
